// File: verilog/svmon_top.sv
// apb control, flag and interrupt logic of the supply voltage monitor
`timescale 1ns/1ps
`include "svmon_regs.svh"

// Notes on behaviour
// - The supply-low flag is set when the comparator reports the supply or external input below the set point.
// - A set supply-low flag with its interrupt enabled raises the interrupt request.
// - Control bits 3 to 0 select one of sixteen trip points.
// - Control bit 5 is a read-only reference-stable bit, 0 after reset and 1 once the reference has settled.
// - The detector is switched purely by software and is fully powered down while off.
// - Setting the enable bit powers comparator and divider and starts detection; clearing it stops both.
// - Trip code 1111 with the enable bit set routes the external trip input to the comparator instead of the divider tap.
// - No supply-low flag is set from the comparator before the reference is reported stable.
// - Reset returns the control register to its reset state, detector off and stable bit cleared.
module svmon_top
#(
  parameter int unsigned ADDR_W        = 8,
  parameter int unsigned SETTLE_CYCLES = `SVMON_SETTLE_CYCLES
)
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              resetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // analog comparator side
  input  wire logic              comparator_low,
  output logic                   detector_power,
  output logic [3:0]             trip_select,
  output logic                   external_trip_input_select,
  // interrupt
  output logic                   peripheral_irq_request
);

  svmon_pkg::svmon_state_s state;
  svmon_pkg::svmon_state_s next_state;

  logic                          reference_stable;
  logic                          setup_phase;
  logic                          access_phase;
  logic                          wr_access;
  logic                          detect_low;
  logic                          settled_event;
  logic [`SVMON_EVENT_COUNT-1:0] events;
  logic [`SVMON_EVENT_COUNT-1:0] w1c;
  svmon_pkg::svmon_reg_e         access_reg;

  generate
    if (ADDR_W < 4 || ADDR_W > 32)
    begin : g_bad_addr
      $error("address width must lie between 4 and 32");
    end
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 8192)
    begin : g_bad_settle
      $error("settle count must lie between 1 and 8192");
    end
  endgenerate

  // word address decode shared by the read setup and the write access
  function automatic svmon_pkg::svmon_reg_e decode(input logic [ADDR_W-1:0] addr);
    svmon_pkg::svmon_reg_e r;
    r = svmon_pkg::SVMON_REG_NONE;
    if (addr == ADDR_W'(`SVMON_CTRL_ADDR))
    begin
      r = svmon_pkg::SVMON_REG_CTRL;
    end
    else if (addr == ADDR_W'(`SVMON_STATUS_ADDR))
    begin
      r = svmon_pkg::SVMON_REG_STATUS;
    end
    else if (addr == ADDR_W'(`SVMON_MASK_ADDR))
    begin
      r = svmon_pkg::SVMON_REG_MASK;
    end
    return r;
  endfunction

  // control register image as software sees it
  function automatic logic [31:0] ctrl_image(input logic en, input logic [3:0] trip, input logic stable);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[`SVMON_TRIP_MSB:`SVMON_TRIP_LSB] = trip;
    v[`SVMON_ENABLE_BIT]               = en;
    v[`SVMON_STABLE_BIT]               = stable;
    return v;
  endfunction

  svmon_settle
  #(
    .CYCLES (SETTLE_CYCLES),
    .CNT_W  (13)
  )
  u_settle
  (
    .clock  (clock),
    .resetn (resetn),
    .enable (state.enable),
    .stable (reference_stable)
  );

  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign access_reg   = decode(paddr);
  assign wr_access    = access_phase && pwrite && pstrb[0];

  // comparator is only believed once powered and settled
  assign detect_low    = state.enable && reference_stable && comparator_low;
  assign settled_event = reference_stable && !state.prev_stable;

  always_comb
  begin
    events                     = '0;
    events[`SVMON_LOW_BIT]     = detect_low;
    events[`SVMON_SETTLED_BIT] = settled_event;
  end

  always_comb
  begin
    w1c = '0;
    if (wr_access && access_reg == svmon_pkg::SVMON_REG_STATUS)
    begin
      w1c = pwdata[`SVMON_EVENT_COUNT-1:0];
    end
  end

  always_comb
  begin
    next_state             = state;
    next_state.prev_stable = reference_stable;
    // a new event beats a clear in the same cycle
    next_state.status      = (state.status & ~w1c) | events;
    if (wr_access)
    begin
      unique case (access_reg)
        svmon_pkg::SVMON_REG_CTRL:
        begin
          // trip code passes as written; reserved low codes are software's concern
          next_state.trip   = pwdata[`SVMON_TRIP_MSB:`SVMON_TRIP_LSB];
          next_state.enable = pwdata[`SVMON_ENABLE_BIT];
        end
        svmon_pkg::SVMON_REG_MASK:
        begin
          next_state.mask = pwdata[`SVMON_EVENT_COUNT-1:0];
        end
        svmon_pkg::SVMON_REG_STATUS:
        begin
          next_state.mask = state.mask;
        end
        svmon_pkg::SVMON_REG_NONE:
        begin
          next_state.mask = state.mask;
        end
      endcase
    end
    if (setup_phase && !pwrite)
    begin
      // read data captured in setup so the access phase needs no wait
      unique case (access_reg)
        svmon_pkg::SVMON_REG_CTRL:
        begin
          next_state.prdata = ctrl_image(state.enable, state.trip, reference_stable);
        end
        svmon_pkg::SVMON_REG_STATUS:
        begin
          next_state.prdata = {{(32 - `SVMON_EVENT_COUNT){1'b0}}, state.status};
        end
        svmon_pkg::SVMON_REG_MASK:
        begin
          next_state.prdata = {{(32 - `SVMON_EVENT_COUNT){1'b0}}, state.mask};
        end
        svmon_pkg::SVMON_REG_NONE:
        begin
          next_state.prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      // detector off, default trip code, flags and masks clear
      state.enable      <= 1'b0;
      state.trip        <= `SVMON_TRIP_RESET;
      state.status      <= `SVMON_STATUS_RESET;
      state.mask        <= `SVMON_MASK_RESET;
      state.prdata      <= 32'h0000_0000;
      state.prev_stable <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // apb answers
  assign pready  = 1'b1;
  assign pslverr = access_phase && (access_reg == svmon_pkg::SVMON_REG_NONE);
  assign prdata  = state.prdata;

  // analog controls
  assign detector_power             = state.enable;
  assign trip_select                = state.trip;
  assign external_trip_input_select = state.enable && (state.trip == `SVMON_TRIP_EXTERNAL);

  // level interrupt from any unmasked sticky flag
  assign peripheral_irq_request = |(state.status & state.mask);

  AST_FLAG_SET: assert property (@(posedge clock) disable iff (!resetn)
    (state.enable && reference_stable && comparator_low) |=> state.status[`SVMON_LOW_BIT])
    else $error("supply-low flag not set after a low report");

  AST_IRQ_RAISE: assert property (@(posedge clock) disable iff (!resetn)
    (detect_low && state.mask[`SVMON_LOW_BIT] && !(wr_access && access_reg == svmon_pkg::SVMON_REG_MASK))
    |=> peripheral_irq_request)
    else $error("enabled supply-low flag did not raise the interrupt");

  AST_TRIP_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    (wr_access && access_reg == svmon_pkg::SVMON_REG_CTRL)
    |=> trip_select == $past(pwdata[`SVMON_TRIP_MSB:`SVMON_TRIP_LSB]))
    else $error("trip select does not follow the control write");

  AST_STABLE_READ: assert property (@(posedge clock) disable iff (!resetn)
    (setup_phase && !pwrite && access_reg == svmon_pkg::SVMON_REG_CTRL)
    |=> prdata[`SVMON_STABLE_BIT] == $past(reference_stable) && prdata[7:6] == 2'b00)
    else $error("control read shows a wrong stable bit");

  AST_POWER_OFF: assert property (@(posedge clock) disable iff (!resetn)
    (wr_access && access_reg == svmon_pkg::SVMON_REG_CTRL && !pwdata[`SVMON_ENABLE_BIT])
    |=> !detector_power ##1 !reference_stable)
    else $error("detector still powered after disable");

  AST_POWER_ON: assert property (@(posedge clock) disable iff (!resetn)
    (wr_access && access_reg == svmon_pkg::SVMON_REG_CTRL && pwdata[`SVMON_ENABLE_BIT])
    |=> detector_power)
    else $error("detector not powered after enable");

  AST_EXT_ROUTE: assert property (@(posedge clock) disable iff (!resetn)
    external_trip_input_select |-> trip_select == 4'hF && detector_power)
    else $error("external input routed under a wrong trip code");

  AST_NO_EARLY_FLAG: assert property (@(posedge clock) disable iff (!resetn)
    $rose(state.status[`SVMON_LOW_BIT]) |-> $past(reference_stable) && $past(state.enable))
    else $error("supply-low flag set before the reference settled");

  AST_RESET_STATE: assert property (@(posedge clock)
    !resetn |=> !detector_power && trip_select == 4'h5 && !reference_stable && !peripheral_irq_request)
    else $error("reset did not restore the control register");

  AST_IRQ_QUIET: assert property (@(posedge clock) disable iff (!resetn)
    (state.mask == '0) |-> !peripheral_irq_request)
    else $error("interrupt raised with every source masked");

  AST_MASK_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    (wr_access && access_reg == svmon_pkg::SVMON_REG_MASK)
    |=> state.mask == $past(pwdata[`SVMON_EVENT_COUNT-1:0]))
    else $error("mask register does not follow the write");

  AST_FLAG_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
    (wr_access && access_reg == svmon_pkg::SVMON_REG_STATUS && pwdata[`SVMON_LOW_BIT] && !detect_low)
    |=> !state.status[`SVMON_LOW_BIT])
    else $error("supply-low flag not cleared by a one written to it");

  AST_FLAG_STICKY: assert property (@(posedge clock) disable iff (!resetn)
    (state.status[`SVMON_LOW_BIT] && !w1c[`SVMON_LOW_BIT]) |=> state.status[`SVMON_LOW_BIT])
    else $error("supply-low flag dropped without a clear");

  AST_NO_FLAG_OFF: assert property (@(posedge clock) disable iff (!resetn)
    !detector_power |=> !$rose(state.status[`SVMON_LOW_BIT]))
    else $error("supply-low flag set while the detector was off");

  AST_UNMAPPED_KEEP: assert property (@(posedge clock) disable iff (!resetn)
    (wr_access && access_reg == svmon_pkg::SVMON_REG_NONE) |=> $stable(detector_power) && $stable(trip_select))
    else $error("write to an unmapped address changed the control register");

  AST_STRB_KEEP: assert property (@(posedge clock) disable iff (!resetn)
    (access_phase && pwrite && !pstrb[0]) |=> $stable(trip_select) && $stable(detector_power))
    else $error("write without its low byte strobe changed the control register");

  AST_CTRL_IMAGE: assert property (@(posedge clock) disable iff (!resetn)
    (setup_phase && !pwrite && access_reg == svmon_pkg::SVMON_REG_CTRL)
    |=> prdata[4:0] == {$past(state.enable), $past(state.trip)} && prdata[31:6] == '0)
    else $error("control read shows wrong trip or enable bits");

  AST_EXT_SELECT: assert property (@(posedge clock) disable iff (!resetn)
    (detector_power && trip_select == `SVMON_TRIP_EXTERNAL) |-> external_trip_input_select)
    else $error("external input not routed under the external trip code");

  AST_SETTLED_FLAG: assert property (@(posedge clock) disable iff (!resetn)
    $rose(reference_stable) |=> state.status[`SVMON_SETTLED_BIT])
    else $error("reference-settled event not flagged");

  AST_SETTLE_DROP: assert property (@(posedge clock) disable iff (!resetn)
    $fell(detector_power) |=> !reference_stable)
    else $error("reference still reported stable after power down");

endmodule

// File: verilog/svmon_regs.svh
// register map, field positions, reset values and timing of the supply monitor
`ifndef SVMON_REGS_SVH
`define SVMON_REGS_SVH

// byte addresses on the apb bus
`define SVMON_CTRL_ADDR      8'h00
`define SVMON_STATUS_ADDR    8'h04
`define SVMON_MASK_ADDR      8'h08

// supply_monitor_control fields
`define SVMON_TRIP_LSB       0
`define SVMON_TRIP_MSB       3
`define SVMON_ENABLE_BIT     4
`define SVMON_STABLE_BIT     5
`define SVMON_CTRL_RESET     8'h05
`define SVMON_TRIP_RESET     4'h5
`define SVMON_TRIP_EXTERNAL  4'hF

// interrupt status and mask fields
`define SVMON_LOW_BIT        0
`define SVMON_SETTLED_BIT    1
`define SVMON_EVENT_COUNT    2
`define SVMON_STATUS_RESET   2'h0
`define SVMON_MASK_RESET     2'h0

// reference settling time
`define SVMON_CLK_NS         5
`define SVMON_SETTLE_NS      20000
`define SVMON_SETTLE_CYCLES  ((`SVMON_SETTLE_NS + `SVMON_CLK_NS - 1) / `SVMON_CLK_NS)

`endif

// File: verilog/svmon_pkg.sv
// types shared by the supply monitor modules
`include "svmon_regs.svh"

package svmon_pkg;

  typedef enum logic [1:0]
  {
    SVMON_REG_CTRL   = 2'b00,
    SVMON_REG_STATUS = 2'b01,
    SVMON_REG_MASK   = 2'b10,
    SVMON_REG_NONE   = 2'b11
  } svmon_reg_e;

  typedef struct packed
  {
    logic                            enable;
    logic [3:0]                      trip;
    logic [`SVMON_EVENT_COUNT-1:0]   status;
    logic [`SVMON_EVENT_COUNT-1:0]   mask;
    logic [31:0]                     prdata;
    logic                            prev_stable;
  } svmon_state_s;

endpackage

// File: verilog/svmon_settle.sv
// reference settling counter of the supply monitor
`timescale 1ns/1ps
`include "svmon_regs.svh"

module svmon_settle
#(
  parameter int unsigned CYCLES = `SVMON_SETTLE_CYCLES,
  parameter int unsigned CNT_W  = 13
)
(
  // clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // control and result
  input  wire logic enable,
  output logic      stable
);

  typedef struct packed
  {
    logic [CNT_W-1:0] count;
    logic             stable;
  } svmon_settle_s;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  svmon_settle_s state;
  svmon_settle_s next_state;

  generate
    if (CYCLES < 1 || CYCLES > (2 ** CNT_W))
    begin : g_bad_cycles
      $error("settle count does not fit the counter");
    end
  endgenerate

  always_comb
  begin
    next_state = state;
    if (!enable)
    begin
      // off: forget any settling progress
      next_state.count  = '0;
      next_state.stable = 1'b0;
    end
    else if (!state.stable)
    begin
      if (state.count == LAST)
      begin
        next_state.stable = 1'b1;
      end
      else
      begin
        next_state.count = state.count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign stable = state.stable;

  AST_SETTLE_OFF: assert property (@(posedge clock) disable iff (!resetn) !enable |=> !stable)
    else $error("reference stable while detector off");

  AST_SETTLE_TIME: assert property (@(posedge clock) disable iff (!resetn)
    $rose(stable) |-> (state.count == LAST) && $past(enable))
    else $error("reference stable before the settling count ran out");

endmodule

// File: tb/svmon_supply_model.sv
// comparator and divider model on the analog side of the supply monitor
`timescale 1ns/1ps

module svmon_supply_model
(
  // control from the block
  input  wire logic       detector_power,
  input  wire logic [3:0] trip_select,
  input  wire logic       external_trip_input_select,
  // analog levels given as codes
  input  wire logic [3:0] supply_level,
  input  wire logic       external_low,
  // comparator result
  output logic            comparator_low
);
  // a powered-down comparator never reports low
  always_comb
  begin
    if (!detector_power)
      comparator_low = 1'b0;
    else if (external_trip_input_select)
      comparator_low = external_low;
    else
      comparator_low = (supply_level < trip_select);
  end
endmodule

// File: tb/svmon_top_test.sv
// self-checking testbench of the supply monitor
`timescale 1ns/1ps
`include "svmon_regs.svh"

module svmon_top_test;
  localparam logic [7:0] a_ctl = `SVMON_CTRL_ADDR;
  localparam logic [7:0] a_sts = `SVMON_STATUS_ADDR;
  localparam logic [7:0] a_msk = `SVMON_MASK_ADDR;
  logic        clock = 1'b0;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [3:0]  strb_cfg;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        comparator_low;
  logic        detector_power;
  logic [3:0]  trip_select;
  logic        ext_sel;
  logic        irq;
  logic [3:0]  supply_level;
  logic        external_low;
  logic [31:0] rd;
  logic        err;
  int          num_errors = 0;
  int          comparisons = 0;
  int          i;

  always #2.5 clock = ~clock;

  svmon_top #(.ADDR_W(8), .SETTLE_CYCLES(8)) u_dut
  (
    .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .comparator_low(comparator_low), .detector_power(detector_power),
    .trip_select(trip_select), .external_trip_input_select(ext_sel), .peripheral_irq_request(irq)
  );

  svmon_supply_model u_model
  (
    .detector_power(detector_power), .trip_select(trip_select), .external_trip_input_select(ext_sel),
    .supply_level(supply_level), .external_low(external_low), .comparator_low(comparator_low)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one apb transfer; read data and error taken at the completing edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    pstrb <= strb_cfg;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      num_errors++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000);
    check(rd, exp);
  endtask

  // irq, external select, power and trip code packed as seen at mid cycle
  task automatic pins(input logic [6:0] exp);
    @(negedge clock);
    check({25'h0, irq, ext_sel, detector_power, trip_select}, {25'h0, exp});
  endtask

  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    strb_cfg = 4'hF;
    supply_level = 4'hF;
    external_low = 1'b0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    pins(7'h05);
    rd_chk(a_ctl, 32'h0000_0005);
    rd_chk(a_sts, 32'h0000_0000);
    rd_chk(a_msk, 32'h0000_0000);
    // reserved lowest trip codes are never written
    for (i = 2; i < 16; i++)
    begin
      apb(1'b1, a_ctl, 32'h0000_0020 | 32'(i));
      rd_chk(a_ctl, 32'(i));
      pins(7'(i));
    end
    strb_cfg = 4'hE;
    apb(1'b1, a_ctl, 32'h0000_001A);
    strb_cfg = 4'hF;
    rd_chk(a_ctl, 32'h0000_000F);
    @(posedge clock);
    supply_level <= 4'h0;
    apb(1'b1, a_ctl, 32'h0000_001A);
    pins(7'h1A);
    rd_chk(a_sts, 32'h0000_0000);
    rd_chk(a_ctl, 32'h0000_001A);
    i = 0;
    do
    begin
      apb(1'b0, a_ctl, 32'h0000_0000);
      i++;
    end
    while (rd[5] !== 1'b1 && i < 20);
    check(rd, 32'h0000_003A);
    rd_chk(a_sts, 32'h0000_0003);
    apb(1'b1, a_msk, 32'h0000_0001);
    pins(7'h5A);
    @(posedge clock);
    supply_level <= 4'hF;
    apb(1'b1, a_sts, 32'h0000_0003);
    rd_chk(a_sts, 32'h0000_0000);
    pins(7'h1A);
    @(posedge clock);
    supply_level <= 4'h9;
    rd_chk(a_sts, 32'h0000_0001);
    pins(7'h5A);
    apb(1'b1, a_ctl, 32'h0000_001F);
    apb(1'b1, a_sts, 32'h0000_0001);
    rd_chk(a_sts, 32'h0000_0000);
    pins(7'h3F);
    @(posedge clock);
    external_low <= 1'b1;
    rd_chk(a_sts, 32'h0000_0001);
    apb(1'b1, a_ctl, 32'h0000_000F);
    pins(7'h4F);
    rd_chk(a_ctl, 32'h0000_000F);
    apb(1'b1, a_sts, 32'h0000_0003);
    rd_chk(a_sts, 32'h0000_0000);
    apb(1'b1, a_ctl, 32'h0000_001F);
    rd_chk(a_ctl, 32'h0000_001F);
    apb(1'b1, 8'h0C, 32'h0000_00FF);
    check({31'h0, err}, 32'h0000_0001);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    check(rd, 32'h0000_0000);
    rd_chk(a_msk, 32'h0000_0001);
    @(posedge clock);
    resetn <= 1'b0;
    @(posedge clock);
    resetn <= 1'b1;
    pins(7'h05);
    rd_chk(a_ctl, 32'h0000_0005);
    rd_chk(a_msk, 32'h0000_0000);
    rd_chk(a_sts, 32'h0000_0000);
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    print_verdict();
  end
endmodule
